// [rtl/tpio_top.v]
// Timer channel 4/5 pin control, register A capture and enable registers
//
// Notes on behaviour
// RULE1 - Output mode: 00 disables pin, 01 drives low
// RULE2 - Code 10 drives pin high on match
// RULE3 - Code 11 toggles; bit 2 sets start level
// RULE4 - Capture mode 00 latches on rising edge
// RULE5 - Capture code 01 latches on falling edge
// RULE6 - Capture bit 1 set: both edges
// RULE7 - Channel 4 11xx captures on channel 3 event
// RULE8 - Six 8-bit read/write enable registers
// RULE9 - Bit 7 gates converter start request
// RULE10 - Converter enable resets 0, blocks request
// RULE11 - Bit 6 reads one, writes ignored
// RULE12 - Bit 5 gates underflow on 1,2,4,5
// RULE13 - Bit 5 reserved zero on 0 and 3
// RULE14 - Underflow enable resets 0, blocks request
// RULE15 - Enable set: request follows underflow flag
// RULE16 - Request is flag AND enable, level
//
// Implementation choices: the Avalon-MM slave port and the address map.
`include "tpio_consts.vh"

module tpio_top #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rst_n,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Channel 4 pin and timing
    input wire ch4_pin_a_in,
    output reg ch4_pin_a_out,
    output reg ch4_pin_a_oe,
    input wire ch4_cmp_match,
    input wire [WIDTH-1:0] ch4_count,
    // Channel 5 pin and timing
    input wire ch5_pin_a_in,
    output reg ch5_pin_a_out,
    output reg ch5_pin_a_oe,
    input wire ch5_cmp_match,
    input wire [WIDTH-1:0] ch5_count,
    // Channel 3 register A event
    input wire ch3_gra_event,
    // Capture strobes and converter start requests
    output reg ch4_capture,
    output reg ch5_capture,
    output reg ch4_adc_start,
    output reg ch5_adc_start,
    // Underflow flags from the status registers, one per channel
    input wire [5:0] underflow_flag,
    output reg [5:0] underflow_irq
);

    reg [7:0] ch4_pin_io_control_reg;
    reg [7:0] ch5_pin_io_control_reg;
    reg [7:0] channel_interrupt_enable_reg [0:5];
    reg [31:0] rd_next;
    reg [5:0] irq_next;
    wire req;
    wire take;
    wire wr_take;
    wire [5:0] ier_idx;
    wire ier_hit;
    wire ch4_ctrl_wr;
    wire ch5_ctrl_wr;
    wire ch4_gra_wr;
    wire ch5_gra_wr;
    wire [WIDTH-1:0] ch4_general_reg_a;
    wire [WIDTH-1:0] ch5_general_reg_a;
    wire ch4_out;
    wire ch4_oe;
    wire ch5_out;
    wire ch5_oe;
    wire ch4_capt;
    wire ch5_capt;
    wire ch4_event;
    wire ch5_event;
    integer i;
    integer j;

    // True for channels whose bit 5 is reserved
    function no_udf;
        input integer ch;
        begin
            no_udf = (ch == `TPIO_CH_NO_UDF_A) || (ch == `TPIO_CH_NO_UDF_B);
        end
    endfunction

    // Apply fixed bits of an enable register value
    function [7:0] ier_fix;
        input [7:0] d;
        input integer ch;
        reg [7:0] v;
        begin
            v = d;
            v[`TPIO_IER_RSV1] = 1'b1;
            if (no_udf(ch))
                v[`TPIO_IER_UDF] = 1'b0;
            ier_fix = v;
        end
    endfunction

    // Bus decode: a request is accepted when waitrequest is low
    assign req = avs_read | avs_write;
    assign take = req & ~avs_waitrequest;
    assign wr_take = take & avs_write;
    assign ier_idx = (avs_address - `TPIO_OFF_IER_BASE) >> 2;
    assign ier_hit = (avs_address >= `TPIO_OFF_IER_BASE) &&
        (avs_address <= `TPIO_OFF_IER_LAST) && (avs_address[1:0] == 2'h0);
    assign ch4_ctrl_wr = wr_take && (avs_address == `TPIO_OFF_CH4_CTRL);
    assign ch5_ctrl_wr = wr_take && (avs_address == `TPIO_OFF_CH5_CTRL);
    assign ch4_gra_wr = wr_take && (avs_address == `TPIO_OFF_CH4_GRA);
    assign ch5_gra_wr = wr_take && (avs_address == `TPIO_OFF_CH5_GRA);

    // One wait cycle per access, then a single ready cycle
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~(req & avs_waitrequest);
    end

    // Read data mux; unmapped addresses read as zero
    always @*
    begin
        rd_next = `TPIO_RD_ZERO;
        if (avs_address == `TPIO_OFF_CH4_CTRL)
            rd_next[7:0] = ch4_pin_io_control_reg;
        else if (avs_address == `TPIO_OFF_CH5_CTRL)
            rd_next[7:0] = ch5_pin_io_control_reg;
        else if (avs_address == `TPIO_OFF_CH4_GRA)
            rd_next[WIDTH-1:0] = ch4_general_reg_a;
        else if (avs_address == `TPIO_OFF_CH5_GRA)
            rd_next[WIDTH-1:0] = ch5_general_reg_a;
        else if (ier_hit)
            rd_next[7:0] = channel_interrupt_enable_reg[ier_idx[2:0]]; // RULE8
    end

    // Read data is loaded during the wait cycle and holds afterwards
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= `TPIO_RD_ZERO;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= rd_next;
    end

    // Pin control registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch4_pin_io_control_reg <= `TPIO_CTRL_RST;
            ch5_pin_io_control_reg <= `TPIO_CTRL_RST;
        end
        else
        begin
            if (ch4_ctrl_wr)
                ch4_pin_io_control_reg <= avs_writedata[7:0];
            if (ch5_ctrl_wr)
                ch5_pin_io_control_reg <= avs_writedata[7:0];
        end
    end

    // Per-channel enable registers with fixed reserved bits
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < `TPIO_NCH; i = i + 1)
                channel_interrupt_enable_reg[i] <= `TPIO_IER_RST; // RULE10 RULE14
        end
        else
        begin
            for (i = 0; i < `TPIO_NCH; i = i + 1)
            begin
                if (wr_take && ier_hit && (ier_idx == i))
                    channel_interrupt_enable_reg[i] <=
                        ier_fix(avs_writedata[7:0], i); // RULE8 RULE11 RULE13
            end
        end
    end

    // Channel 4 register A: capture may come from channel 3
    tpio_chan #(
        .WIDTH(WIDTH),
        .HAS_CH3_SRC(1)
    ) u_ch4 (
        .clk(clk),
        .rst_n(rst_n),
        .ctrl(ch4_pin_io_control_reg[3:0]),
        .ctrl_wr(ch4_ctrl_wr),
        .ctrl_new(avs_writedata[3:0]),
        .pin_in(ch4_pin_a_in),
        .cmp_match(ch4_cmp_match),
        .ch3_event(ch3_gra_event),
        .count(ch4_count),
        .sw_wr(ch4_gra_wr),
        .sw_data(avs_writedata[WIDTH-1:0]),
        .gra_reg(ch4_general_reg_a),
        .pin_out_reg(ch4_out),
        .pin_oe_reg(ch4_oe),
        .capt_reg(ch4_capt),
        .event_reg(ch4_event)
    );

    // Channel 5 register A: bit 2 has no effect in capture mode
    tpio_chan #(
        .WIDTH(WIDTH),
        .HAS_CH3_SRC(0)
    ) u_ch5 (
        .clk(clk),
        .rst_n(rst_n),
        .ctrl(ch5_pin_io_control_reg[3:0]),
        .ctrl_wr(ch5_ctrl_wr),
        .ctrl_new(avs_writedata[3:0]),
        .pin_in(ch5_pin_a_in),
        .cmp_match(ch5_cmp_match),
        .ch3_event(1'b0),
        .count(ch5_count),
        .sw_wr(ch5_gra_wr),
        .sw_data(avs_writedata[WIDTH-1:0]),
        .gra_reg(ch5_general_reg_a),
        .pin_out_reg(ch5_out),
        .pin_oe_reg(ch5_oe),
        .capt_reg(ch5_capt),
        .event_reg(ch5_event)
    );

    // Pin and capture outputs, straight from the channel flops
    always @*
    begin
        ch4_pin_a_out = ch4_out;
        ch4_pin_a_oe = ch4_oe;
        ch5_pin_a_out = ch5_out;
        ch5_pin_a_oe = ch5_oe;
        ch4_capture = ch4_capt;
        ch5_capture = ch5_capt;
    end

    // Converter start requests gated by bit 7
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch4_adc_start <= 1'b0;
            ch5_adc_start <= 1'b0;
        end
        else
        begin
            ch4_adc_start <= ch4_event &
                channel_interrupt_enable_reg[`TPIO_CH4][`TPIO_IER_ADC]; // RULE9 RULE10
            ch5_adc_start <= ch5_event &
                channel_interrupt_enable_reg[`TPIO_CH5][`TPIO_IER_ADC]; // RULE9 RULE10
        end
    end

    // Underflow requests: flag AND enable, none on channels 0 and 3
    // Own loop variable so that no clocked process shares it
    always @*
    begin
        for (j = 0; j < `TPIO_NCH; j = j + 1)
        begin
            if (no_udf(j))
                irq_next[j] = 1'b0; // RULE13
            else
                irq_next[j] = underflow_flag[j] &
                    channel_interrupt_enable_reg[j][`TPIO_IER_UDF]; // RULE12 RULE15 RULE16
        end
    end

    // Registered underflow request level
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            underflow_irq <= 6'h00;
        else
            underflow_irq <= irq_next; // RULE14
    end

endmodule

// [shared/tpio_consts.vh]
// Constants for the timer channel 4/5 pin control and enable block
`ifndef TPIO_CONSTS_VH
`define TPIO_CONSTS_VH

// Register byte offsets on the bus
`define TPIO_OFF_CH4_CTRL 6'h00
`define TPIO_OFF_CH5_CTRL 6'h04
`define TPIO_OFF_CH4_GRA 6'h08
`define TPIO_OFF_CH5_GRA 6'h0C
`define TPIO_OFF_IER_BASE 6'h10
`define TPIO_OFF_IER_LAST 6'h24

// Control field bit positions
`define TPIO_CTL_MODE 3
`define TPIO_CTL_LVL 2
`define TPIO_CTL_ACT_HI 1
`define TPIO_CTL_ACT_LO 0

// Match actions in output compare mode
`define TPIO_ACT_OFF 2'h0
`define TPIO_ACT_LOW 2'h1
`define TPIO_ACT_HIGH 2'h2
`define TPIO_ACT_TOGGLE 2'h3

// Interrupt enable register bits
`define TPIO_IER_ADC 7
`define TPIO_IER_RSV1 6
`define TPIO_IER_UDF 5

// Reset values
`define TPIO_CTRL_RST 8'h00
`define TPIO_IER_RST 8'h40
`define TPIO_RD_ZERO 32'h0000_0000

// Channel numbering
`define TPIO_NCH 6
`define TPIO_CH_NO_UDF_A 0
`define TPIO_CH_NO_UDF_B 3
`define TPIO_CH4 4
`define TPIO_CH5 5

`endif

// [rtl/tpio_chan.v]
// One channel's register A: compare pin driver and input capture
`include "tpio_consts.vh"

module tpio_chan #(
    parameter WIDTH = 16,
    parameter HAS_CH3_SRC = 0
) (
    input wire clk,
    input wire rst_n,
    input wire [3:0] ctrl,
    input wire ctrl_wr,
    input wire [3:0] ctrl_new,
    input wire pin_in,
    input wire cmp_match,
    input wire ch3_event,
    input wire [WIDTH-1:0] count,
    input wire sw_wr,
    input wire [WIDTH-1:0] sw_data,
    output reg [WIDTH-1:0] gra_reg,
    output reg pin_out_reg,
    output reg pin_oe_reg,
    output reg capt_reg,
    output reg event_reg
);

    reg pin_d_reg;
    wire cap_mode;
    wire ch3_src;
    wire rise;
    wire fall;
    wire edge_hit;
    wire capt;
    wire [1:0] act;

    // Mode decode
    assign cap_mode = ctrl[`TPIO_CTL_MODE];
    assign ch3_src = (HAS_CH3_SRC != 0) && cap_mode && ctrl[`TPIO_CTL_LVL]; // RULE7
    assign act = ctrl[`TPIO_CTL_ACT_HI:`TPIO_CTL_ACT_LO];
    assign rise = pin_in & ~pin_d_reg; // RULE4
    assign fall = ~pin_in & pin_d_reg; // RULE5
    // Bit 1 set takes both edges and ignores bit 0
    assign edge_hit = act[1] ? (rise | fall) : (act[0] ? fall : rise); // RULE6
    assign capt = cap_mode & (ch3_src ? ch3_event : edge_hit); // RULE7

    // Pin sampling, capture register and events
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_d_reg <= 1'b0;
            gra_reg <= {WIDTH{1'b0}};
            capt_reg <= 1'b0;
            event_reg <= 1'b0;
        end
        else
        begin
            pin_d_reg <= pin_in;
            capt_reg <= capt;
            event_reg <= capt | (~cap_mode & cmp_match);
            if (capt)
                gra_reg <= count; // RULE4
            else if (sw_wr)
                gra_reg <= sw_data;
        end
    end

    // Output pin level and enable
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            // Load the initial level when a new setting arrives
            pin_out_reg <= ctrl_new[`TPIO_CTL_LVL]; // RULE3
            pin_oe_reg <= ~ctrl_new[`TPIO_CTL_MODE] &
                (ctrl_new[`TPIO_CTL_ACT_HI:`TPIO_CTL_ACT_LO] != `TPIO_ACT_OFF); // RULE1
        end
        else
        begin
            pin_oe_reg <= ~cap_mode & (act != `TPIO_ACT_OFF); // RULE1
            if (~cap_mode & cmp_match)
            begin
                case (act)
                    `TPIO_ACT_LOW: pin_out_reg <= 1'b0; // RULE1
                    `TPIO_ACT_HIGH: pin_out_reg <= 1'b1; // RULE2
                    `TPIO_ACT_TOGGLE: pin_out_reg <= ~pin_out_reg; // RULE3
                    default: pin_out_reg <= pin_out_reg;
                endcase
            end
        end
    end

endmodule

// [testbench/tpio_chk_assertions.sv]
// Port-level checker for the channel 4/5 pin control block
module tpio_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic ch4_cmp_match,
    input wire logic ch5_cmp_match,
    input wire logic ch4_pin_a_out,
    input wire logic ch5_pin_a_in,
    input wire logic ch4_capture,
    input wire logic ch5_capture,
    input wire logic ch4_adc_start,
    input wire logic ch5_adc_start,
    input wire logic [5:0] underflow_flag,
    input wire logic [5:0] underflow_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Request only where its flag was set
    udf_flag_gate_a: assert property ((underflow_irq & ~$past(underflow_flag)) == 6'h00)
        else $error("underflow request without its flag");
    // Channels 0 and 3 never raise it
    rsv_irq_zero_a: assert property (underflow_irq[0] == 1'b0 && underflow_irq[3] == 1'b0)
        else $error("underflow request on channel 0 or 3");
    // Bus answers last exactly one cycle and follow a request
    wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low for more than one cycle");
    wait_needs_req_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    // Converter starts follow a capture or a match
    adc4_cause_a: assert property (ch4_adc_start |-> $past(ch4_capture) ||
        $past(ch4_cmp_match) || $past(ch4_cmp_match, 2))
        else $error("channel 4 start without event");
    adc5_cause_a: assert property (ch5_adc_start |-> $past(ch5_capture) ||
        $past(ch5_cmp_match) || $past(ch5_cmp_match, 2))
        else $error("channel 5 start without event");
    // A channel 5 capture needs a pin change just before it
    capt5_edge_a: assert property (ch5_capture |->
        ($past(ch5_pin_a_in) != $past(ch5_pin_a_in, 2)) ||
        ($past(ch5_pin_a_in, 2) != $past(ch5_pin_a_in, 3)))
        else $error("capture without edge");
    // Pin level moves only on a match or a register write
    pin4_hold_a: assert property ($changed(ch4_pin_a_out) |->
        $past(ch4_cmp_match) || $past(avs_write))
        else $error("pin changed without cause");
    cover property (ch4_capture);
    cover property (ch5_adc_start);
    cover property (|underflow_irq);
endmodule
bind tpio_top tpio_chk i_tpio_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ch4_cmp_match(ch4_cmp_match),
    .ch5_cmp_match(ch5_cmp_match), .ch4_pin_a_out(ch4_pin_a_out), .ch5_pin_a_in(ch5_pin_a_in),
    .ch4_capture(ch4_capture), .ch5_capture(ch5_capture), .ch4_adc_start(ch4_adc_start),
    .ch5_adc_start(ch5_adc_start), .underflow_flag(underflow_flag), .underflow_irq(underflow_irq));

// [testbench/tpio_far.sv]
// Far-side model: pin wires, counter value and event strobes
module tpio_far (
    input wire logic clk,
    input wire logic p4_out,
    input wire logic p4_oe,
    input wire logic p5_out,
    input wire logic p5_oe,
    output logic p4_in,
    output logic p5_in,
    output logic [2:0] ev,
    output logic [15:0] cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic e4 = 1'b0;
    logic e5 = 1'b0;
    initial ev = 3'h0;
    initial cnt = 16'h0000;
    // Block drive wins while enabled, else the outside level
    assign p4_in = p4_oe ? p4_out : e4;
    assign p5_in = p5_oe ? p5_out : e5;
    // Load the count seen by both channels
    task automatic load(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
    endtask
    // Outside pin level, changed just after an edge
    task automatic set_pin(input logic is5, input logic lvl);
        @(posedge clk);
        if (is5)
            e5 <= lvl;
        else
            e4 <= lvl;
    endtask
    // One-cycle strobe: bit 0 ch4 match, bit 1 ch5 match, bit 2 ch3 event
    task automatic strobe(input logic [2:0] which);
        @(posedge clk);
        ev <= which;
        @(posedge clk);
        ev <= 3'h0;
    endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the channel 4/5 pin control block
`include "tpio_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, p4_in, p5_in, p4_out, p4_oe, p5_out, p5_oe, c4, c5, a4, a5;
    logic [2:0] ev;
    logic [15:0] cnt;
    logic [5:0] uflag = 6'h00;
    logic [5:0] uirq;
    logic [7:0] cc [4] = '{8'h08, 8'h09, 8'h0A, 8'h0C};
    int ce [4] = '{1, 1, 2, 1};
    int err_total = 0;
    int num_checks = 0;
    int n4c = 0, n5c = 0, n4a = 0, n5a = 0, b;
    always #50 clk = ~clk;
    // Count capture and converter start pulses
    always @(posedge clk)
    begin
        n4c <= n4c + int'(c4);
        n5c <= n5c + int'(c5);
        n4a <= n4a + int'(a4);
        n5a <= n5a + int'(a5);
    end
    tpio_top i_tpio_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ch4_pin_a_in(p4_in),
        .ch4_pin_a_out(p4_out), .ch4_pin_a_oe(p4_oe), .ch4_cmp_match(ev[0]), .ch4_count(cnt),
        .ch5_pin_a_in(p5_in), .ch5_pin_a_out(p5_out), .ch5_pin_a_oe(p5_oe), .ch5_cmp_match(ev[1]),
        .ch5_count(cnt), .ch3_gra_event(ev[2]), .ch4_capture(c4), .ch5_capture(c5),
        .ch4_adc_start(a4), .ch5_adc_start(a5), .underflow_flag(uflag), .underflow_irq(uirq));
    tpio_far i_tpio_far (.clk(clk), .p4_out(p4_out), .p4_oe(p4_oe), .p5_out(p5_out),
        .p5_oe(p5_oe), .p4_in(p4_in), .p5_in(p5_in), .ev(ev), .cnt(cnt));
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus transfer, held until wait drops; read data lands in q
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40)
        begin
            err_total++;
            conclude();
        end
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        uflag <= 6'h3F;
        for (int i = 0; i < 6; i++)
            rdc(6'h10 + 6'(4 * i), 32'h0000_0040);
        rdc(`TPIO_OFF_CH4_CTRL, 32'h0000_0000);
        rdc(6'h3C, 32'h0000_0000);
        chk({26'h0, uirq}, 32'h0000_0000);
        $display("test reset values done");
        for (int i = 0; i < 6; i++)
            bus(1'b1, 6'h10 + 6'(4 * i), 32'h0000_00FF);
        for (int i = 0; i < 6; i++)
            rdc(6'h10 + 6'(4 * i), (i == 0 || i == 3) ? 32'h0000_00DF : 32'h0000_00FF);
        chk({26'h0, uirq}, 32'h0000_0036);
        bus(1'b1, 6'h14, 32'h0000_0000);
        rdc(6'h14, 32'h0000_0040);
        chk({26'h0, uirq}, 32'h0000_0034);
        uflag <= 6'h00;
        repeat (2) @(posedge clk);
        chk({26'h0, uirq}, 32'h0000_0000);
        uflag <= 6'h3F;
        $display("test enable registers done");
        bus(1'b1, 6'h20, 32'h0000_0080);
        b = n4a;
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, `TPIO_OFF_CH4_CTRL, 32'(c));
            @(posedge clk);
            chk(p4_oe, c[1:0] != 2'h0);
            chk(p4_out & p4_oe, c[1:0] != 2'h0 && c[2]);
            i_tpio_far.strobe(3'h1);
            repeat (2) @(posedge clk);
            chk(p4_out & p4_oe, c[1:0] == 2'h2 || (c[1:0] == 2'h3 && !c[2]));
        end
        bus(1'b1, 6'h20, 32'h0000_0000);
        chk(n4a - b, 8);
        i_tpio_far.strobe(3'h1);
        repeat (3) @(posedge clk);
        chk(n4a - b, 8);
        $display("test compare output done");
        bus(1'b1, 6'h24, 32'h0000_0080);
        b = n5a;
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, `TPIO_OFF_CH5_CTRL, {24'h00_0000, cc[k]});
            i_tpio_far.load(16'h0A50 + 16'(k));
            b = n5c;
            i_tpio_far.set_pin(1'b1, 1'b1);
            repeat (4) @(posedge clk);
            i_tpio_far.set_pin(1'b1, 1'b0);
            repeat (4) @(posedge clk);
            chk(n5c - b, ce[k]);
            rdc(`TPIO_OFF_CH5_GRA, 32'h0000_0A50 + 32'(k));
        end
        chk(n5a, 5);
        // Channel 5 compare: toggle, low and high actions, then disabled
        bus(1'b1, `TPIO_OFF_CH5_CTRL, 32'h0000_0007);
        @(posedge clk);
        chk({p5_oe, p5_out}, 2'h3);
        i_tpio_far.strobe(3'h2);
        repeat (2) @(posedge clk);
        chk({p5_oe, p5_out}, 2'h2);
        bus(1'b1, `TPIO_OFF_CH5_CTRL, 32'h0000_0005);
        @(posedge clk);
        chk({p5_oe, p5_out}, 2'h3);
        i_tpio_far.strobe(3'h2);
        repeat (2) @(posedge clk);
        chk({p5_oe, p5_out}, 2'h2);
        bus(1'b1, `TPIO_OFF_CH5_CTRL, 32'h0000_0002);
        @(posedge clk);
        chk({p5_oe, p5_out}, 2'h2);
        i_tpio_far.strobe(3'h2);
        repeat (2) @(posedge clk);
        chk({p5_oe, p5_out}, 2'h3);
        bus(1'b1, `TPIO_OFF_CH5_CTRL, 32'h0000_0004);
        i_tpio_far.strobe(3'h2);
        repeat (3) @(posedge clk);
        chk({p5_oe, p5_out}, 2'h1);
        chk(n5a, 9);
        bus(1'b1, `TPIO_OFF_CH4_CTRL, 32'h0000_000C);
        i_tpio_far.load(16'h0BEE);
        repeat (3) @(posedge clk);
        b = n4c;
        i_tpio_far.set_pin(1'b0, 1'b1);
        repeat (4) @(posedge clk);
        chk(n4c - b, 0);
        i_tpio_far.strobe(3'h4);
        repeat (3) @(posedge clk);
        chk(n4c - b, 1);
        rdc(`TPIO_OFF_CH4_GRA, 32'h0000_0BEE);
        // Channel 4 pin edges: falling capture, then rising capture
        bus(1'b1, `TPIO_OFF_CH4_CTRL, 32'h0000_0009);
        i_tpio_far.load(16'h0C01);
        b = n4c;
        i_tpio_far.set_pin(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk(n4c - b, 1);
        rdc(`TPIO_OFF_CH4_GRA, 32'h0000_0C01);
        bus(1'b1, `TPIO_OFF_CH4_CTRL, 32'h0000_0008);
        i_tpio_far.load(16'h0C02);
        i_tpio_far.set_pin(1'b0, 1'b1);
        repeat (4) @(posedge clk);
        chk(n4c - b, 2);
        rdc(`TPIO_OFF_CH4_GRA, 32'h0000_0C02);
        $display("test input capture done");
        conclude();
    end
endmodule
